/* hdl/gpio_port.sv */
// gpio port pin registers: byte, word, direction, mask, pin, masked pin, set, clear, toggle
// assumes the core's local i/o port presents one request per cycle and takes read data
// on the next edge; clkEn is the bus clock gate bit driven by the system control block
//
// What this block does
// - byte register bit 0 reads pin level whatever direction or mask, zero in analog mode
// - pins in analog mode read zero through byte and word registers
// - byte register write loads bit 0 into the pin output bit
// - byte register bits 7:1 read zero, writes to them ignored
// - one byte register per pin at 0x0000..0x0012, lanes per access size
// - word registers from 0x1000 read all zeros or all ones by pin level
// - word register write: zero clears output bit, nonzero sets it
// - every register takes byte, halfword and word accesses at natural width
// - every access completes in one clock cycle without wait states
// - after reset all pins are inputs, direction register is zero
// - direction bit one makes pin output, zero input, bits 17:0
// - port pin register at 0x2100, masked pin register at 0x2180
// - port pin register writes load output bits ignoring mask
// - mask zero enables masked access, one blocks writes and zeroes reads
// - masked read is pins and not mask, masked write only unmasked bits
// - 0x2200 sets output bits on write, reads output bits, resets zero
// - pin level registers reset to zero in the synchroniser, then follow the pins
// - port-wide registers laid out for 32 pins, unbonded positions reserved; byte and word areas stop at 0x0012 and 0x1048
`timescale 1ns/1ps
module gpio_port
  import gpio_port_pkg::*;
#(
  parameter int NPINS = NUM_PINS
)(
  // clock, reset, bus clock gate
  input  wire logic             ref_clk,
  input  wire logic             rstn,
  input  wire logic             clkEn,
  // local i/o port
  input  wire io_req_s          ioReq,
  output logic      [31:0]      ioRdata,
  // pads
  input  wire logic [NPINS-1:0] padIn,
  input  wire logic [NPINS-1:0] analogMode,
  output logic      [NPINS-1:0] padOut,
  output logic      [NPINS-1:0] padOe
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [31:0]      dir_r;
  logic [31:0]      mask_r;
  logic [31:0]      out_r;
  logic [31:0]      out_nxt;
  logic [31:0]      rdata_nxt;
  logic [NPINS-1:0] pinSync;
  logic [31:0]      pinLvl;
  logic [3:0]       laneEn;
  logic [31:0]      laneMask;
  logic [13:0]      wordAddr;
  logic             wr;

  // ----------------------------------------
  // pin sampling
  // ----------------------------------------
  // levels follow pins
  pin_sync #(
    .WIDTH   (NPINS)
  ) u_sync (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .clkEn   (clkEn),
    .asyncIn (padIn),
    .syncOut (pinSync)
  );

  // analog pins read as zero; unbonded positions read zero
  // analog reads zero
  always_comb
  begin
    pinLvl = '0;
    pinLvl[NPINS-1:0] = pinSync & ~analogMode;
  end

  // ----------------------------------------
  // byte lanes
  // ----------------------------------------
  // natural width lanes
  always_comb
  begin
    if (ioReq.size == SIZE_BYTE)
      laneEn = 4'h1 << ioReq.addr[1:0];
    else if (ioReq.size == SIZE_HALF)
      laneEn = ioReq.addr[1] ? 4'hc : 4'h3;
    else
      laneEn = 4'hf;
  end

  always_comb
  begin
    laneMask = {{8{laneEn[3]}}, {8{laneEn[2]}}, {8{laneEn[1]}}, {8{laneEn[0]}}};
  end

  assign wordAddr = {ioReq.addr[13:2], 2'h0};
  assign wr       = ioReq.sel && ioReq.write;

  // ----------------------------------------
  // output bit next value
  // ----------------------------------------
  // write data sits in its lane; a narrower write touches only its lanes
  always_comb
  begin
    out_nxt = out_r;
    if (wr)
    begin
      if (wordAddr <= OFS_BYTE_LAST)
      begin
        for (int l = 0; l < 4; l++)
          if (laneEn[l])
            out_nxt[{wordAddr[4:0] + 5'(l)}] = ioReq.wdata[8*l + PIN_BIT_POS];
      end
      else if (wordAddr >= OFS_WORD_BASE && wordAddr <= OFS_WORD_LAST)
      begin
        out_nxt[wordAddr[6:2]] = |(ioReq.wdata & laneMask);
      end
      else if (wordAddr == OFS_PIN)
      begin
        out_nxt = (out_r & ~laneMask) | (ioReq.wdata & laneMask);
      end
      else if (wordAddr == OFS_MPIN)
      begin
        out_nxt = (out_r & ~(laneMask & ~mask_r)) | (ioReq.wdata & laneMask & ~mask_r);
      end
      else if (wordAddr == OFS_SET)
      begin
        out_nxt = out_r | (ioReq.wdata & laneMask);
      end
      else if (wordAddr == OFS_CLR)
      begin
        out_nxt = out_r & ~(ioReq.wdata & laneMask);
      end
      else if (wordAddr == OFS_NOT)
      begin
        out_nxt = out_r ^ (ioReq.wdata & laneMask);
      end
    end
  end

  // output bits; all 32 kept so reserved positions can be written (unbonded pads)
  // 32-bit layout
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      out_r <= RST_OUT;
    else if (clkEn)
      out_r <= out_nxt;
  end

  // direction register, partial writes by lane
  // reset to inputs
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      dir_r <= RST_DIR;
    else if (clkEn && wr && wordAddr == OFS_DIR)
      dir_r <= (dir_r & ~laneMask) | (ioReq.wdata & laneMask);
  end

  // mask register
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      mask_r <= RST_MASK;
    else if (clkEn && wr && wordAddr == OFS_MASK)
      mask_r <= (mask_r & ~laneMask) | (ioReq.wdata & laneMask);
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  // data is placed in full word position; the core picks its lanes
  always_comb
  begin
    rdata_nxt = RST_RDATA;
    if (wordAddr <= OFS_BYTE_LAST)
    begin
      for (int l = 0; l < 4; l++)
        rdata_nxt[8*l + PIN_BIT_POS] = pinLvl[{wordAddr[4:0] + 5'(l)}];
    end
    else if (wordAddr >= OFS_WORD_BASE && wordAddr <= OFS_WORD_LAST)
    begin
      rdata_nxt = {32{pinLvl[wordAddr[6:2]]}};
    end
    else if (wordAddr == OFS_DIR)
      rdata_nxt = dir_r;
    else if (wordAddr == OFS_MASK)
      rdata_nxt = mask_r;
    else if (wordAddr == OFS_PIN)
      rdata_nxt = pinLvl;
    else if (wordAddr == OFS_MPIN)
      rdata_nxt = pinLvl & ~mask_r;
    else if (wordAddr == OFS_SET)
      rdata_nxt = out_r;
    rdata_nxt = rdata_nxt & laneMask;
  end

  // read data registered; answer at the next edge, no wait state
  // single cycle
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      ioRdata <= RST_RDATA;
    else if (clkEn)
      ioRdata <= (ioReq.sel && !ioReq.write) ? rdata_nxt : RST_RDATA;
  end

  // ----------------------------------------
  // pads
  // ----------------------------------------
  // direction one drives
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      padOut <= '0;
      padOe  <= '0;
    end
    else if (clkEn)
    begin
      padOut <= out_nxt[NPINS-1:0];
      padOe  <= dir_r[NPINS-1:0];
    end
  end

endmodule : gpio_port

/* hdl/gpio_port_pkg.sv */
// package for the gpio port block: register offsets, widths, reset values, bus carrier
// assumes a single-cycle local i/o port with byte, halfword and word accesses
package gpio_port_pkg;

  // ----------------------------------------
  // geometry
  // ----------------------------------------
  localparam int          NUM_PINS      = 18;
  localparam int          PORT_BITS     = 32;
  localparam int          ADDR_BITS     = 14;

  // ----------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [13:0] OFS_BYTE_BASE = 14'h0000;
  localparam logic [13:0] OFS_BYTE_LAST = 14'h0012;
  localparam logic [13:0] OFS_WORD_BASE = 14'h1000;
  localparam logic [13:0] OFS_WORD_LAST = 14'h1048;
  localparam logic [13:0] OFS_DIR       = 14'h2000;
  localparam logic [13:0] OFS_MASK      = 14'h2080;
  localparam logic [13:0] OFS_PIN       = 14'h2100;
  localparam logic [13:0] OFS_MPIN      = 14'h2180;
  localparam logic [13:0] OFS_SET       = 14'h2200;
  localparam logic [13:0] OFS_CLR       = 14'h2280;
  localparam logic [13:0] OFS_NOT       = 14'h2300;

  // ----------------------------------------
  // field positions and reset values
  // ----------------------------------------
  localparam int          PIN_BIT_POS   = 0;
  localparam logic [31:0] RST_DIR       = 32'h0000_0000;
  localparam logic [31:0] RST_MASK      = 32'h0000_0000;
  localparam logic [31:0] RST_OUT       = 32'h0000_0000;
  localparam logic [31:0] RST_RDATA     = 32'h0000_0000;

  // access size codes
  localparam logic [1:0]  SIZE_BYTE     = 2'h0;
  localparam logic [1:0]  SIZE_HALF     = 2'h1;
  localparam logic [1:0]  SIZE_WORD     = 2'h2;

  // one request on the local i/o port
  typedef struct packed {
    logic        sel;
    logic        write;
    logic [1:0]  size;
    logic [13:0] addr;
    logic [31:0] wdata;
  } io_req_s;

endpackage : gpio_port_pkg

/* hdl/pin_sync.sv */
// two-stage synchroniser for the pad levels
// assumes pads are asynchronous to ref_clk
`timescale 1ns/1ps
module pin_sync
  import gpio_port_pkg::*;
#(
  parameter int WIDTH = 18
)(
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rstn,
  input  wire logic             clkEn,
  // levels
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] meta_r;

  // first stage feeds only the second
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      meta_r  <= '0;
      syncOut <= '0;
    end
    else if (clkEn)
    begin
      meta_r  <= asyncIn;
      syncOut <= meta_r;
    end
  end

endmodule : pin_sync

/* verif/gpio_port_sva.sv */
// checker for gpio_port: timing of the local i/o port and the pad outputs
// assumes the bind below reaches every gpio_port instance
`timescale 1ns/1ps
module gpio_port_sva
  import gpio_port_pkg::*;
#(
  parameter int NPINS = NUM_PINS
)(
  // clock and reset
  input wire logic             ref_clk,
  input wire logic             rstn,
  input wire logic             clkEn,
  // port and pads
  input wire io_req_s          ioReq,
  input wire logic [31:0]      ioRdata,
  input wire logic [NPINS-1:0] padIn,
  input wire logic [NPINS-1:0] analogMode,
  input wire logic [NPINS-1:0] padOut,
  input wire logic [NPINS-1:0] padOe
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // taken word write, taken read
  logic wrOk;
  logic rdOk;
  assign wrOk = clkEn && ioReq.sel && ioReq.write && ioReq.size == SIZE_WORD;
  assign rdOk = clkEn && ioReq.sel && !ioReq.write;
  property p_idle; $past(clkEn) && !$past(rdOk) |-> ioRdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("read data not idle");
  property p_dir; wrOk && ioReq.addr == OFS_DIR ##1 clkEn
    |=> padOe == $past(ioReq.wdata[NPINS-1:0], 2); endproperty
  a_dir: assert property (p_dir) else $error("enable differs from direction");
  property p_set; wrOk && ioReq.addr == OFS_SET
    |=> padOut == ($past(padOut) | $past(ioReq.wdata[NPINS-1:0])); endproperty
  a_set: assert property (p_set) else $error("set wrong");
  property p_clr; wrOk && ioReq.addr == OFS_CLR
    |=> padOut == ($past(padOut) & ~$past(ioReq.wdata[NPINS-1:0])); endproperty
  a_clr: assert property (p_clr) else $error("clear wrong");
  property p_tgl; wrOk && ioReq.addr == OFS_NOT
    |=> padOut == ($past(padOut) ^ $past(ioReq.wdata[NPINS-1:0])); endproperty
  a_tgl: assert property (p_tgl) else $error("toggle wrong");
  property p_pin; wrOk && ioReq.addr == OFS_PIN
    |=> padOut == $past(ioReq.wdata[NPINS-1:0]); endproperty
  a_pin: assert property (p_pin) else $error("pin write wrong");
  property p_wrd; rdOk && ioReq.addr == OFS_WORD_BASE && ioReq.size == SIZE_WORD
    |=> ioRdata inside {32'h0, 32'hffffffff}; endproperty
  a_wrd: assert property (p_wrd) else $error("word pin read not uniform");
  property p_ana; rdOk && ioReq.addr == OFS_PIN
    |=> (ioRdata[NPINS-1:0] & $past(analogMode)) == '0 && ioRdata[31:NPINS] == '0; endproperty
  a_ana: assert property (p_ana) else $error("analog or absent pin not zero");
  // a wider read of the byte area returns one level bit per lane, never bits 7:1 of a lane
  property p_bhi; rdOk && ioReq.addr <= OFS_BYTE_LAST
    |=> (ioRdata & 32'hfefe_fefe) == 32'h0; endproperty
  a_bhi: assert property (p_bhi) else $error("byte upper bits set");
  // a gated bus clock must freeze the pads
  property p_frz; !clkEn |=> $stable(padOut) && $stable(padOe); endproperty
  a_frz: assert property (p_frz) else $error("state moved while gated");
endmodule : gpio_port_sva
bind gpio_port gpio_port_sva #(.NPINS(NPINS)) u_sva (.ref_clk(ref_clk), .rstn(rstn),
  .clkEn(clkEn), .ioReq(ioReq), .ioRdata(ioRdata), .padIn(padIn),
  .analogMode(analogMode), .padOut(padOut), .padOe(padOe));

/* verif/pad_model.sv */
// pad model: the far side of the pins
// assumes an undriven pad follows an outside source
`timescale 1ns/1ps
module pad_model
  import gpio_port_pkg::*;
(
  // from the port and from outside
  input  wire logic [NUM_PINS-1:0] drive,
  input  wire logic [NUM_PINS-1:0] oe,
  input  wire logic [NUM_PINS-1:0] ext,
  // level seen on the pad
  output logic      [NUM_PINS-1:0] level
);
  // a driven pad shows its output bit, so reads can prove writes landed
  assign level = (drive & oe) | (ext & ~oe);
endmodule : pad_model

/* verif/test_gpio_port.sv */
// testbench for gpio_port: register accesses and pad levels
// assumes pad_model on the pins and the bound checker
`timescale 1ns/1ps
module test_gpio_port;
  import gpio_port_pkg::*;
  logic          ref_clk = 1'b0;
  logic          rstn    = 1'b0;
  logic          clkEn   = 1'b1;
  io_req_s       ioReq   = '0;
  logic [17:0]   ext     = 18'h2a5a5;
  logic [17:0]   analog  = '0;
  logic [31:0]   ioRdata;
  logic [17:0]   padIn;
  logic [17:0]   padOut;
  logic [17:0]   padOe;
  logic [31:0]   o;
  int            n_errors    = 0;
  int            check_count = 0;
  always #2 ref_clk = ~ref_clk;
  gpio_port u_dut (.ref_clk(ref_clk), .rstn(rstn), .clkEn(clkEn), .ioReq(ioReq),
    .ioRdata(ioRdata), .padIn(padIn), .analogMode(analog), .padOut(padOut), .padOe(padOe));
  pad_model u_pads (.drive(padOut), .oe(padOe), .ext(ext), .level(padIn));
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one request, held until the edge that takes it
  task automatic xfer(input logic w, input logic [1:0] sz, input logic [13:0] a,
                      input logic [31:0] d);
    @(posedge ref_clk);
    ioReq <= '{1'b1, w, sz, a, d};
    @(posedge ref_clk);
    ioReq.sel <= 1'b0;
    #1;
  endtask : xfer
  task automatic rd(input logic [1:0] sz, input logic [13:0] a, input logic [31:0] e);
    xfer(1'b0, sz, a, 32'h0);
    chk(ioRdata, e);
  endtask : rd
  // pad levels pass a synchroniser, so wait before reading them
  task automatic settle();
    repeat (3) @(posedge ref_clk);
  endtask : settle
  initial
  begin
    #20000;
    n_errors++;
    wrap_up();
  end
  initial
  begin
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    rd(SIZE_WORD, OFS_DIR, 32'h0);
    rd(SIZE_WORD, OFS_MASK, 32'h0);
    rd(SIZE_WORD, OFS_SET, 32'h0);
    chk({14'h0, padOe}, 32'h0);
    rd(SIZE_WORD, OFS_PIN, {14'h0, ext});
    for (int i = 0; i < 18; i++)
    begin
      rd(SIZE_BYTE, OFS_BYTE_BASE + i[13:0], {31'h0, ext[i]} << (8 * (i % 4)));
      rd(SIZE_WORD, OFS_WORD_BASE + 14'(4 * i), {32{ext[i]}});
    end
    rd(SIZE_HALF, 14'h0002, {7'h0, ext[3], 7'h0, ext[2], 16'h0});
    rd(SIZE_WORD, 14'h0004, {7'h0, ext[7], 7'h0, ext[6], 7'h0, ext[5], 7'h0, ext[4]});
    rd(SIZE_HALF, 14'h1006, {{16{ext[1]}}, 16'h0});
    xfer(1'b1, SIZE_WORD, OFS_DIR, 32'h3ffff);
    rd(SIZE_WORD, OFS_DIR, 32'h3ffff);
    chk({14'h0, padOe}, 32'h3ffff);
    o = 32'hc0015555;
    xfer(1'b1, SIZE_WORD, OFS_PIN, o);
    rd(SIZE_WORD, OFS_SET, o);
    xfer(1'b1, SIZE_WORD, OFS_SET, 32'h0000_0f0f);
    xfer(1'b1, SIZE_WORD, OFS_CLR, 32'h0001_0101);
    xfer(1'b1, SIZE_WORD, OFS_NOT, 32'h0000_00ff);
    o = ((o | 32'hf0f) & ~32'h10101) ^ 32'hff;
    rd(SIZE_WORD, OFS_SET, o);
    rd(SIZE_WORD, OFS_CLR, 32'h0);
    xfer(1'b1, SIZE_BYTE, 14'h0005, 32'h0000_fe00);
    xfer(1'b1, SIZE_BYTE, 14'h0006, 32'h00ff_0000);
    xfer(1'b1, SIZE_WORD, 14'h101c, 32'h8000_0000);
    xfer(1'b1, SIZE_WORD, 14'h1020, 32'h0);
    o = (o & ~32'h120) | 32'hc0;
    rd(SIZE_WORD, OFS_SET, o);
    settle();
    rd(SIZE_BYTE, 14'h0006, 32'h0001_0000);
    xfer(1'b1, SIZE_WORD, OFS_MASK, 32'hff);
    xfer(1'b1, SIZE_WORD, OFS_MPIN, 32'h3ff00);
    o = (o & 32'hff) | 32'h3ff00;
    settle();
    rd(SIZE_WORD, OFS_MPIN, o & 32'h3ff00);
    rd(SIZE_WORD, OFS_PIN, o & 32'h3ffff);
    @(posedge ref_clk) analog <= 18'h1;
    rd(SIZE_BYTE, OFS_BYTE_BASE, 32'h0);
    rd(SIZE_WORD, OFS_PIN, o & 32'h3fffe);
    rd(SIZE_WORD, OFS_WORD_BASE, 32'h0);
    xfer(1'b1, SIZE_HALF, OFS_MASK + 14'h2, 32'h0003_0000);
    rd(SIZE_WORD, OFS_MASK, 32'h0003_00ff);
    rd(SIZE_BYTE, OFS_SET + 14'h1, o & 32'h0000_ff00);
    rd(SIZE_WORD, 14'h3000, 32'h0);
    @(posedge ref_clk) clkEn <= 1'b0;
    xfer(1'b1, SIZE_WORD, OFS_SET, 32'h2);
    @(posedge ref_clk) clkEn <= 1'b1;
    rd(SIZE_WORD, OFS_SET, o);
    wrap_up();
  end
endmodule : test_gpio_port
